// file: rtl/ppm_pkg.sv
// Constants shared by the port pin mode control block.
`default_nettype none
package ppm_pkg;
  // Pin slots: bits 0 to 7 are port one, bits 8 to 15 are port three.
  localparam int NPIN = 16;
  localparam logic [15:0] IO_PIN_MASK = 16'h3FFF;
  localparam logic [15:0] CMP_PIN_MASK = 16'h0003;
  localparam logic [15:0] WAKE_PIN_MASK = 16'h0C08;
  localparam logic [15:0] QUASI_KEEP_MASK = 16'h0010;
  localparam logic [15:0] XTAL_CLAIM_MASK = 16'h0C00;
  localparam logic [15:0] EXTCLK_CLAIM_MASK = 16'h0400;
  localparam logic [15:0] RSTPIN_CLAIM_MASK = 16'h0008;

  // Register byte offsets.
  localparam logic [7:0] PIN_LEVEL_OFS = 8'h00;
  localparam logic [7:0] LATCH_OFS = 8'h04;
  localparam logic [7:0] LATCH_SET_OFS = 8'h08;
  localparam logic [7:0] LATCH_CLR_OFS = 8'h0C;
  localparam logic [7:0] MODE_LOW_OFS = 8'h10;
  localparam logic [7:0] MODE_HIGH_OFS = 8'h14;
  localparam logic [7:0] CMP_CTRL_OFS = 8'h18;
  localparam logic [7:0] AVAIL_OFS = 8'h1C;
  localparam int CMP_EN_BIT = 0;

  // Reset values.
  localparam logic [15:0] LATCH_RST = 16'hFFFF;
  localparam logic [15:0] MODE_LOW_RST_TRI = 16'hFFEF;
  localparam logic [15:0] MODE_LOW_RST_QUASI = 16'h0003;
  localparam logic [15:0] MODE_HIGH_RST = 16'h0000;
  localparam logic CMP_EN_RST = 1'h0;

  // Pin modes as {high bit, low bit}.
  localparam logic [1:0] MODE_QUASI = 2'h0;
  localparam logic [1:0] MODE_INPUT = 2'h1;
  localparam logic [1:0] MODE_PUSH_PULL = 2'h2;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;

  // Clock source straps.
  localparam logic [1:0] CLK_CRYSTAL = 2'h0;
  localparam logic [1:0] CLK_EXTERNAL = 2'h1;
  localparam logic [1:0] CLK_INTERNAL = 2'h2;

  // Strong pull-up pulse length in core clock cycles.
  localparam int STRONG_PULSE_CYCLES = 2;
  localparam logic [1:0] STRONG_PULSE_LOAD = 2'(STRONG_PULSE_CYCLES - 1);
endpackage
`default_nettype wire

// file: rtl/ppm_sync.sv
// Two flip-flop synchroniser for the pad inputs.
`default_nettype none
module ppm_sync #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;
endmodule
`default_nettype wire

// file: rtl/ppm_pin_cell.sv
// Driver control for one pad: pull-ups, pull-down and strong pull-up pulse.
`default_nettype none
module ppm_pin_cell (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic latch_i,
  input wire logic level_i,
  input wire logic drive_en_i,
  output logic very_weak_pu_o,
  output logic weak_pu_o,
  output logic strong_pu_o,
  output logic pull_down_o
);
  logic prev_latch;
  logic next_prev_latch;
  logic [1:0] pulse_cnt;
  logic [1:0] next_pulse_cnt;
  logic is_quasi;
  logic is_pp;
  logic is_od;
  logic rise;

  assign is_quasi = drive_en_i && (mode_i == ppm_pkg::MODE_QUASI);
  assign is_pp = drive_en_i && (mode_i == ppm_pkg::MODE_PUSH_PULL);
  assign is_od = drive_en_i && (mode_i == ppm_pkg::MODE_OPEN_DRAIN);
  assign rise = latch_i && !prev_latch;

  always_comb begin
    next_prev_latch = latch_i;
    next_pulse_cnt = 2'h0;
    if (is_quasi && rise) begin
      next_pulse_cnt = ppm_pkg::STRONG_PULSE_LOAD;
    end else if (is_quasi && latch_i && pulse_cnt != 2'h0) begin
      next_pulse_cnt = pulse_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_latch <= 1'h1;
      pulse_cnt <= 2'h0;
    end else begin
      prev_latch <= next_prev_latch;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // Input-only mode and claimed pins fall through to all drivers off.
  assign very_weak_pu_o = is_quasi && latch_i;
  assign weak_pu_o = is_quasi && latch_i && level_i;
  assign strong_pu_o = (is_quasi && latch_i && (rise || pulse_cnt != 2'h0))
                    || (is_pp && latch_i);
  assign pull_down_o = (is_quasi || is_pp || is_od) && !latch_i;

  ////////////////////////////////////////////////////////////////////////
  a_strong_pulse_len: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_quasi && rise) ##1 (is_quasi && latch_i) [*2]
    |-> $past(strong_pu_o, 2) && $past(strong_pu_o) && !strong_pu_o)
    else $error("Strong pull-up pulse is not two cycles.");
  a_quasi_pull_down: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_quasi && !latch_i) |-> pull_down_o && !very_weak_pu_o && !strong_pu_o)
    else $error("Quasi pin with latch low is not pulled down.");
  a_input_all_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_i == ppm_pkg::MODE_INPUT)
    |-> !(very_weak_pu_o || weak_pu_o || strong_pu_o || pull_down_o))
    else $error("Input-only pin has a driver on.");
  a_od_no_pullup: assert property (@(posedge clk_i) disable iff (rst_i)
    is_od |-> !(very_weak_pu_o || weak_pu_o || strong_pu_o) && (pull_down_o == !latch_i))
    else $error("Open-drain pin drive is wrong.");
  a_pp_strong_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_pp && latch_i) [*3] |-> strong_pu_o && $past(strong_pu_o, 2) && !pull_down_o)
    else $error("Push-pull pin does not hold its strong pull-up.");
  a_weak_follows_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    is_quasi |-> (weak_pu_o == (latch_i && level_i)) && (very_weak_pu_o == latch_i))
    else $error("Quasi weak pull-ups do not follow latch and pin.");
endmodule
`default_nettype wire

// file: rtl/ppm_port_ctrl.sv
// Top of the port pin mode control block with its Wishbone register slave.
`default_nettype none
module ppm_port_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Static configuration and core status.
  input wire logic tristate_fuse_i,
  input wire logic [1:0] clk_src_i,
  input wire logic rst_pin_keep_i,
  input wire logic power_down_i,
  // Pads.
  input wire logic [15:0] pad_level_i,
  output logic [15:0] very_weak_pu_o,
  output logic [15:0] weak_pu_o,
  output logic [15:0] strong_pu_o,
  output logic [15:0] pull_down_o,
  output logic [15:0] input_power_gate_o,
  output logic [15:0] pin_avail_o
);
  localparam int NP = ppm_pkg::NPIN;

  ////////////////////////////////////////////////////////////////////////
  // Byte-lane merge used by the latch and mode registers.
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] d,
                                             input logic [1:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Pins that are left to the ports once the clock and reset pins are claimed.
  function automatic logic [15:0] avail_mask(input logic [1:0] src, input logic keep);
    logic [15:0] m;
    m = ppm_pkg::IO_PIN_MASK;
    case (src)
      ppm_pkg::CLK_CRYSTAL: m = m & ~ppm_pkg::XTAL_CLAIM_MASK;
      ppm_pkg::CLK_EXTERNAL: m = m & ~ppm_pkg::EXTCLK_CLAIM_MASK;
      default: m = m;
    endcase
    if (keep) begin
      m = m & ~ppm_pkg::RSTPIN_CLAIM_MASK;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [15:0] latch;
  logic [15:0] next_latch;
  logic [15:0] mode_select_low_bit;
  logic [15:0] next_mode_select_low_bit;
  logic [15:0] mode_select_high_bit;
  logic [15:0] next_mode_select_high_bit;
  logic comparator_enable;
  logic next_comparator_enable;
  logic [15:0] avail;
  logic [15:0] next_avail;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic req;
  logic wr;
  logic [7:0] ofs;
  logic [15:0] sensed;
  logic [15:0] pad_sync;
  logic [15:0] gate;
  logic [15:0] wd;

  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && ack && wb_we_i;
  assign ofs = 8'(wb_adr_i);
  assign wd = wb_dat_i[15:0];

  always_comb begin
    next_ack = req && !ack;
    next_rdata = rdata;
    next_latch = latch;
    next_mode_select_low_bit = mode_select_low_bit;
    next_mode_select_high_bit = mode_select_high_bit;
    next_comparator_enable = comparator_enable;
    next_avail = avail;
    if (req && !ack && !wb_we_i) begin
      case (ofs)
        ppm_pkg::PIN_LEVEL_OFS: next_rdata = {16'h0000, sensed};
        ppm_pkg::LATCH_OFS: next_rdata = {16'h0000, latch};
        ppm_pkg::MODE_LOW_OFS: next_rdata = {16'h0000, mode_select_low_bit};
        ppm_pkg::MODE_HIGH_OFS: next_rdata = {16'h0000, mode_select_high_bit};
        ppm_pkg::CMP_CTRL_OFS: next_rdata = {31'h0, comparator_enable};
        ppm_pkg::AVAIL_OFS: next_rdata = {16'h0000, avail};
        default: next_rdata = 32'h00000000;
      endcase
    end
    if (wr) begin
      case (ofs)
        ppm_pkg::PIN_LEVEL_OFS: next_latch = lane_merge(latch, wd, wb_sel_i[1:0]);
        ppm_pkg::LATCH_OFS: next_latch = lane_merge(latch, wd, wb_sel_i[1:0]);
        ppm_pkg::LATCH_SET_OFS: next_latch = latch | lane_merge(16'h0000, wd, wb_sel_i[1:0]);
        ppm_pkg::LATCH_CLR_OFS: next_latch = latch & ~lane_merge(16'h0000, wd, wb_sel_i[1:0]);
        ppm_pkg::MODE_LOW_OFS: begin
          next_mode_select_low_bit = lane_merge(mode_select_low_bit, wd, wb_sel_i[1:0]);
        end
        ppm_pkg::MODE_HIGH_OFS: begin
          next_mode_select_high_bit = lane_merge(mode_select_high_bit, wd, wb_sel_i[1:0]);
        end
        ppm_pkg::CMP_CTRL_OFS: begin
          if (wb_sel_i[0]) begin
            next_comparator_enable = wb_dat_i[ppm_pkg::CMP_EN_BIT];
          end
        end
        default: next_latch = latch;
      endcase
    end
  end

  // Straps are caught on the reset cycles, so they must be stable across reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'h0;
      rdata <= 32'h00000000;
      latch <= ppm_pkg::LATCH_RST;
      if (tristate_fuse_i) begin
        mode_select_low_bit <= ppm_pkg::MODE_LOW_RST_TRI;
      end else begin
        mode_select_low_bit <= ppm_pkg::MODE_LOW_RST_QUASI;
      end
      mode_select_high_bit <= ppm_pkg::MODE_HIGH_RST;
      comparator_enable <= ppm_pkg::CMP_EN_RST;
      avail <= avail_mask(clk_src_i, rst_pin_keep_i);
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      latch <= next_latch;
      mode_select_low_bit <= next_mode_select_low_bit;
      mode_select_high_bit <= next_mode_select_high_bit;
      comparator_enable <= next_comparator_enable;
      avail <= next_avail;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign pin_avail_o = avail;

  ////////////////////////////////////////////////////////////////////////
  // Input power gating and sensed levels.
  always_comb begin
    gate = avail;
    if (power_down_i) begin
      gate = gate & ppm_pkg::WAKE_PIN_MASK;
    end
    if (comparator_enable) begin
      gate = gate & ~ppm_pkg::CMP_PIN_MASK;
    end
  end

  assign input_power_gate_o = gate;

  ppm_sync #(
    .W(NP)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pad_level_i),
    .sync_o(pad_sync)
  );

  assign sensed = pad_sync & gate;

  ////////////////////////////////////////////////////////////////////////
  // One driver cell per pad.
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      ppm_pin_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i({mode_select_high_bit[gi], mode_select_low_bit[gi]}),
        .latch_i(latch[gi]),
        .level_i(sensed[gi]),
        .drive_en_i(avail[gi]),
        .very_weak_pu_o(very_weak_pu_o[gi]),
        .weak_pu_o(weak_pu_o[gi]),
        .strong_pu_o(strong_pu_o[gi]),
        .pull_down_o(pull_down_o[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  a_cmp_gate_low: assert property (@(posedge clk_i) disable iff (rst_i)
    comparator_enable |-> (input_power_gate_o & ppm_pkg::CMP_PIN_MASK) == 16'h0000)
    else $error("Comparator pins keep their input buffers on.");
  a_pd_wake_only: assert property (@(posedge clk_i) disable iff (rst_i)
    power_down_i |-> ((input_power_gate_o & ~ppm_pkg::WAKE_PIN_MASK) == 16'h0000)
      && ((input_power_gate_o & ppm_pkg::WAKE_PIN_MASK) == (avail & ppm_pkg::WAKE_PIN_MASK)))
    else $error("Power-down gating of input buffers is wrong.");
  a_reset_mode_tri: assert property (@(posedge clk_i)
    ($past(rst_i) && !rst_i && $past(tristate_fuse_i))
    |-> mode_select_low_bit == ppm_pkg::MODE_LOW_RST_TRI && mode_select_high_bit == 16'h0000)
    else $error("Reset modes with fuse enabled are wrong.");
  a_reset_mode_quasi: assert property (@(posedge clk_i)
    ($past(rst_i) && !rst_i && !$past(tristate_fuse_i))
    |-> mode_select_low_bit == ppm_pkg::MODE_LOW_RST_QUASI && latch == 16'hFFFF)
    else $error("Reset modes with fuse disabled are wrong.");
  a_cmp_pins_input: assert property (@(posedge clk_i)
    ($past(rst_i) && !rst_i) |-> (mode_select_low_bit & ppm_pkg::CMP_PIN_MASK) == 16'h0003)
    else $error("Comparator pins do not reset to input-only.");
  a_latch_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack && !wb_we_i && ofs == ppm_pkg::LATCH_OFS) |=> wb_ack_o
      && wb_dat_o == {16'h0000, $past(latch)})
    else $error("Latch view does not return the latch.");
  a_pin_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack && !wb_we_i && ofs == ppm_pkg::PIN_LEVEL_OFS) |=> wb_ack_o
      && wb_dat_o == {16'h0000, $past(pad_sync) & $past(gate)})
    else $error("Pin view does not return gated synchronised levels.");
  a_avail_count: assert property (@(posedge clk_i) disable iff (rst_i)
    ($countones(avail) >= 11) && ($countones(avail) <= 14))
    else $error("Usable pin count is outside eleven to fourteen.");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge lasts more than one cycle.");

  ////////////////////////////////////////////////////////////////////////
  // Register access checks: a request is taken first and written only in its ack cycle.
  a_ack_after_take: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack) |=> wb_ack_o)
    else $error("Taken request is not acknowledged in the next cycle.");
  a_mode_hold_take: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !ack && wb_we_i && ofs == ppm_pkg::MODE_LOW_OFS)
    |=> mode_select_low_bit == $past(mode_select_low_bit))
    else $error("Mode write took effect before the acknowledge.");
  a_mode_low_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && ofs == ppm_pkg::MODE_LOW_OFS && wb_sel_i[1:0] == 2'h3)
    |=> mode_select_low_bit == $past(wd))
    else $error("Mode low bits are not written per pin.");
  a_mode_high_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && ofs == ppm_pkg::MODE_HIGH_OFS && wb_sel_i[1:0] == 2'h3)
    |=> mode_select_high_bit == $past(wd))
    else $error("Mode high bits are not written per pin.");
  a_latch_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && (ofs == ppm_pkg::LATCH_OFS || ofs == ppm_pkg::PIN_LEVEL_OFS)
      && wb_sel_i[1:0] == 2'h3) |=> latch == $past(wd))
    else $error("Port write does not load the latch.");
  a_latch_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && ofs == ppm_pkg::LATCH_SET_OFS && wb_sel_i[1:0] == 2'h3)
    |=> latch == ($past(latch) | $past(wd)))
    else $error("Latch set view does not modify the latch contents.");
  a_latch_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && ofs == ppm_pkg::LATCH_CLR_OFS && wb_sel_i[1:0] == 2'h3)
    |=> latch == ($past(latch) & ~$past(wd)))
    else $error("Latch clear view does not modify the latch contents.");
  a_cmp_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && ofs == ppm_pkg::CMP_CTRL_OFS && wb_sel_i[0])
    |=> comparator_enable == $past(wb_dat_i[ppm_pkg::CMP_EN_BIT]))
    else $error("Comparator enable is not written.");

  // Pad path checks. The synchroniser clears on reset, so the first two cycles are skipped.
  a_sync_two_flops: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(rst_i, 2))
    |-> pad_sync == $past(pad_level_i, 2))
    else $error("Pad levels do not pass exactly two flip-flops.");
  a_claimed_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ((very_weak_pu_o | weak_pu_o | strong_pu_o | pull_down_o) & ~avail) == 16'h0000
      && (input_power_gate_o & ~avail) == 16'h0000)
    else $error("A claimed pin has a driver or input buffer on.");
  a_gate_awake: assert property (@(posedge clk_i) disable iff (rst_i)
    (!power_down_i && !comparator_enable) |-> input_power_gate_o == avail)
    else $error("Awake input buffers are not all on.");
endmodule
`default_nettype wire

// file: rtl/ppm_unused_guard.sv
// This file declares nothing; the block lives in the other design files.
`default_nettype none
`default_nettype wire

// file: testbench/ppm_pad_model.sv
// Behavioural model of the external circuitry seen by the sixteen pads.
`default_nettype none
module ppm_pad_model (
  input wire logic clk_i,
  input wire logic [15:0] ext_en_i,
  input wire logic [15:0] ext_val_i,
  input wire logic [15:0] very_weak_pu_i,
  input wire logic [15:0] weak_pu_i,
  input wire logic [15:0] strong_pu_i,
  input wire logic [15:0] pull_down_i,
  output logic [15:0] pad_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] floating = 16'h5555;
  logic [15:0] any_pu;
  // An undriven pad shows a pattern that flips every cycle, never a held value.
  always @(posedge clk_i) begin
    floating <= ~floating;
  end
  assign any_pu = very_weak_pu_i | weak_pu_i | strong_pu_i;
  // An external driver overpowers every pull-up of the pad.
  assign pad_o = (ext_en_i & ext_val_i) | (~ext_en_i & ~pull_down_i & (any_pu | floating));
endmodule
`default_nettype wire

// file: testbench/ppm_port_ctrl_tb.sv
// Self-checking testbench of the port pin mode control block.
`default_nettype none
module ppm_port_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, fuse = 1'h0, keep = 1'h0, pdn = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [1:0] src = 2'h2;
  logic [15:0] ext_en = 16'hFFFF, ext_val = 16'hFFFF;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [15:0] pad, vw, w, s, pd, gate, avail, lat, av;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2.5 clk_i = ~clk_i;
  ppm_port_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tristate_fuse_i(fuse), .clk_src_i(src), .rst_pin_keep_i(keep),
    .power_down_i(pdn), .pad_level_i(pad), .very_weak_pu_o(vw), .weak_pu_o(w),
    .strong_pu_o(s), .pull_down_o(pd), .input_power_gate_o(gate), .pin_avail_o(avail));
  ppm_pad_model pads (.clk_i(clk_i), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .very_weak_pu_i(vw), .weak_pu_i(w), .strong_pu_i(s), .pull_down_i(pd), .pad_o(pad));
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      $display("CHECK FAILED at %0t: run did not finish in time", $time);
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One classic cycle; the answer is taken at the edge where ack is seen high.
  task automatic wb_cycle(input logic wr, input logic [7:0] a, input logic [15:0] d,
                          output logic [15:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= wr;
    adr <= a;
    dat <= {16'h0000, d};
    sel <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    r = wb_dat_o[15:0];
    check({31'h0, wb_ack_o}, 32'h1, "bus answer");
    if (!wr) check({16'h0000, wb_dat_o[31:16]}, 32'h0, "upper read bits");
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask
  task automatic wb_write(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    wb_cycle(1'h1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
    logic [15:0] r;
    wb_cycle(1'h0, a, 16'h0000, r);
    check({16'h0000, r}, {16'h0000, exp}, what);
  endtask
  task automatic do_reset(input logic f, input logic [1:0] c, input logic k);
    @(posedge clk_i);
    rst_i <= 1'h1;
    fuse <= f;
    src <= c;
    keep <= k;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    #1;
  endtask
  task automatic drive(input logic [15:0] en, input logic [15:0] val, input logic p);
    @(posedge clk_i);
    ext_en <= en;
    ext_val <= val;
    pdn <= p;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  task automatic chk_drv(input logic [15:0] ev, ew, es, ep);
    check({16'h0, vw}, {16'h0, ev}, "very weak pull-up");
    check({16'h0, w}, {16'h0, ew}, "weak pull-up");
    check({16'h0, s}, {16'h0, es}, "strong pull-up");
    check({16'h0, pd}, {16'h0, ep}, "pull-down");
  endtask
  initial begin
    logic [15:0] claim;
    logic [15:0] m_lo [4] = '{16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF};
    logic [15:0] m_hi [4] = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF};
    int cnt [6] = '{11, 12, 12, 13, 13, 14};
    int hits;
    lat = 16'hA5C3;
    // Reset defaults and usable pin counts for every clock source and reset pin choice.
    for (int i = 0; i < 6; i++) begin
      do_reset(~i[0], 2'(i / 2), ~i[0]);
      claim = (i / 2 == 0) ? 16'h0C00 : (i / 2 == 1) ? 16'h0400 : 16'h0000;
      av = 16'h3FFF & ~claim & (i[0] ? 16'hFFFF : 16'hFFF7);
      check(32'($countones(avail)), 32'(cnt[i]), "usable pin count");
      check({16'h0, avail}, {16'h0, av}, "usable pin mask");
      rd_chk(ppm_pkg::AVAIL_OFS, av, "usable pin register");
      rd_chk(ppm_pkg::MODE_LOW_OFS, i[0] ? 16'h0003 : 16'hFFEF, "mode low reset");
      rd_chk(ppm_pkg::MODE_HIGH_OFS, 16'h0000, "mode high reset");
      rd_chk(ppm_pkg::LATCH_OFS, 16'hFFFF, "latch reset");
      check({16'h0, vw}, {16'h0, av & (i[0] ? 16'hFFFC : 16'h0010)}, "reset pulls");
      check({16'h0, pd}, 32'h0, "reset pull-down");
    end
    $display("Test reset defaults done");
    wb_write(ppm_pkg::LATCH_OFS, lat);
    for (int m = 0; m < 4; m++) begin
      wb_write(ppm_pkg::MODE_LOW_OFS, m_lo[m]);
      wb_write(ppm_pkg::MODE_HIGH_OFS, m_hi[m]);
      drive(16'h0000, 16'h0000, 1'h0);
      case (m)
        0: chk_drv(lat & av, lat & av, 16'h0, ~lat & av);
        1: chk_drv(16'h0, 16'h0, lat & av, ~lat & av);
        2: chk_drv(16'h0, 16'h0, 16'h0, 16'h0);
        default: chk_drv(16'h0, 16'h0, 16'h0, ~lat & av);
      endcase
    end
    $display("Test pin modes done");
    wb_write(ppm_pkg::MODE_LOW_OFS, 16'h0000);
    wb_write(ppm_pkg::MODE_HIGH_OFS, 16'h0000);
    wb_write(ppm_pkg::LATCH_CLR_OFS, 16'h0004);
    repeat (3) @(posedge clk_i);
    wb_write(ppm_pkg::LATCH_SET_OFS, 16'h0004);
    hits = 0;
    #1;
    for (int c = 0; c < 6; c++) begin
      hits += int'(s[2] === 1'h1);
      @(posedge clk_i);
      #1;
    end
    check(32'(hits), 32'(ppm_pkg::STRONG_PULSE_CYCLES), "strong pulse length");
    drive(16'h0000, 16'h0000, 1'h0);
    check({31'h0, w[2]}, 32'h1, "weak on with pin high");
    drive(16'h0004, 16'h0000, 1'h0);
    check({31'h0, w[2]}, 32'h0, "weak off with pin pulled low");
    check({31'h0, vw[2]}, 32'h1, "very weak stays on");
    $display("Test quasi pull-ups done");
    drive(16'hFFFF, 16'h1234, 1'h0);
    rd_chk(ppm_pkg::PIN_LEVEL_OFS, 16'h1234 & av, "plain read gives pins");
    rd_chk(ppm_pkg::LATCH_OFS, 16'hA5C7, "latch view");
    drive(16'hFFFF, 16'hFFFF, 1'h1);
    check({16'h0, gate}, {16'h0, av & 16'h0C08}, "power-down gates");
    rd_chk(ppm_pkg::PIN_LEVEL_OFS, av & 16'h0C08, "power-down sensing");
    drive(16'hFFFF, 16'hFFFF, 1'h0);
    check({16'h0, gate}, {16'h0, av}, "gates open when awake");
    $display("Test sensing and power-down done");
    // Analog use: comparator pins left input-only by software.
    wb_write(ppm_pkg::MODE_LOW_OFS, 16'h0003);
    wb_write(ppm_pkg::CMP_CTRL_OFS, 16'h0001);
    #1;
    check({16'h0, gate}, {16'h0, av & 16'hFFFC}, "comparator gates pins");
    rd_chk(ppm_pkg::CMP_CTRL_OFS, 16'h0001, "comparator enable readback");
    rd_chk(ppm_pkg::PIN_LEVEL_OFS, av & 16'hFFFC, "gated pins read zero");
    wb_write(ppm_pkg::CMP_CTRL_OFS, 16'h0000);
    #1;
    check({16'h0, gate}, {16'h0, av}, "comparator off");
    rd_chk(8'h20, 16'h0000, "unmapped read");
    wb_write(ppm_pkg::AVAIL_OFS, 16'h0000);
    rd_chk(ppm_pkg::AVAIL_OFS, av, "read-only register kept");
    $display("Test comparator and map done");
    print_verdict();
  end
endmodule
`default_nettype wire
